// ### design/ebzat_pkg.sv
/*
  Constants for the external bus zone access sequencer: register offsets,
  field positions, reset values, phase states and field widths.
  Assumes one 20 MHz clock that also serves as the access timing clock.

  // Function
  // - Access runs lead, active, trail in order
  // - One timing register per zone, used per access
  // - Read phases: lead, active+wait+1, trail
  // - Write phases use same formulas as reads
  // - Double programmed counts only, not waits/extra
  // - Wait states count ready holds; zero if disabled
  // - Illegal timing accepted, no flag, no correction
  // - Phases counted and strobes moved on timing clock
  // - Lead starts on bus clock rise; align cycle
*/
package ebzat_pkg;

  // Bus and zone sizes
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ZONES = 3;
  localparam int ZONE_W = 2;
  localparam int LEN_W = 5;
  localparam int WS_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ZONE0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0c;

  // Zone timing field positions
  localparam int F_RD_LEAD = 0;
  localparam int F_RD_ACTIVE = 2;
  localparam int F_RD_TRAIL = 5;
  localparam int F_WR_LEAD = 7;
  localparam int F_WR_ACTIVE = 9;
  localparam int F_WR_TRAIL = 12;
  localparam int F_DOUBLE = 14;
  localparam int F_READY_EN = 15;
  localparam int F_READY_ASYNC = 16;
  localparam int LEAD_W = 2;
  localparam int ACTIVE_W = 3;
  localparam int TRAIL_W = 2;
  localparam int ZT_W = 17;

  // Control and status field positions
  localparam int F_CLK_HALF = 0;
  localparam int F_BUSY = 8;
  localparam int F_LAST_WS = 16;

  // Reset values: longest counts but doubling off, ready ignored, bus clock full rate
  localparam logic [ZT_W-1:0] ZT_RESET = 17'h03fff;
  localparam logic CLK_HALF_RESET = 1'b0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALIGN = 3'b001,
    ST_LEAD = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_TRAIL = 3'b100
  } ebzat_state_e;

endpackage : ebzat_pkg

// ### design/ebzat_ready_sync.sv
/*
  Two-stage synchroniser for the external ready pin.
  Assumes the pin is asynchronous to sys_clk_in.
*/
`timescale 1ns/1ps
module ebzat_ready_sync (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Pin and synchronised level
  input wire logic pin_in,
  output logic sync_out
);

  logic meta_reg; // First stage, read only by the second
  logic sync_reg; // Second stage
  logic meta_next;
  logic sync_next;

  // Next values; reset releases to ready high
  always_comb begin
    meta_next = rst_n_in ? pin_in : 1'b1;
    sync_next = rst_n_in ? meta_reg : 1'b1;
  end

  // Registers only
  always_ff @(posedge sys_clk_in) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg;

endmodule : ebzat_ready_sync

// ### design/ebzat_phase_len.sv
/*
  Turns one zone timing word into lead, active and trail lengths
  in timing clock cycles for a read or a write.
  Assumes the word is stable while the lengths are used.
*/
`timescale 1ns/1ps
module ebzat_phase_len (
  // Timing word and direction
  input wire logic [ebzat_pkg::ZT_W-1:0] timing_in,
  input wire logic wr_in,
  // Lengths and ready mode
  output logic [ebzat_pkg::LEN_W-1:0] lead_len_out,
  output logic [ebzat_pkg::LEN_W-1:0] active_len_out,
  output logic [ebzat_pkg::LEN_W-1:0] trail_len_out,
  output logic ready_en_out,
  output logic ready_async_out
);

  logic [ebzat_pkg::LEAD_W-1:0] lead_f;     // Programmed lead
  logic [ebzat_pkg::ACTIVE_W-1:0] active_f; // Programmed active
  logic [ebzat_pkg::TRAIL_W-1:0] trail_f;   // Programmed trail
  logic dbl;                                // Doubling selected

  // Pick read or write fields, then scale
  always_comb begin
    if (wr_in) begin
      lead_f = timing_in[ebzat_pkg::F_WR_LEAD +: ebzat_pkg::LEAD_W];
      active_f = timing_in[ebzat_pkg::F_WR_ACTIVE +: ebzat_pkg::ACTIVE_W];
      trail_f = timing_in[ebzat_pkg::F_WR_TRAIL +: ebzat_pkg::TRAIL_W];
    end else begin
      lead_f = timing_in[ebzat_pkg::F_RD_LEAD +: ebzat_pkg::LEAD_W];
      active_f = timing_in[ebzat_pkg::F_RD_ACTIVE +: ebzat_pkg::ACTIVE_W];
      trail_f = timing_in[ebzat_pkg::F_RD_TRAIL +: ebzat_pkg::TRAIL_W];
    end
    dbl = timing_in[ebzat_pkg::F_DOUBLE];
    // Counts shift left once when doubled; the extra active cycle is not doubled
    lead_len_out = ebzat_pkg::LEN_W'({3'h0, lead_f} << dbl);
    active_len_out = ebzat_pkg::LEN_W'(({2'h0, active_f} << dbl) + 5'h01);
    trail_len_out = ebzat_pkg::LEN_W'({3'h0, trail_f} << dbl);
    // Wait states only when ready sampling is on
    ready_en_out = timing_in[ebzat_pkg::F_READY_EN];
    ready_async_out = timing_in[ebzat_pkg::F_READY_ASYNC];
  end

endmodule : ebzat_phase_len

// ### design/ebzat_top.sv
/*
  External bus zone access sequencer: zone timing registers, a plain
  register port, and the lead/active/trail state machine driving zone
  select and strobes. Assumes the access timing clock is sys_clk_in and
  that requests come from logic on that clock; the ready pin is external.
  Each access spends one setup cycle, selects high, before its lead.
  A request is held off while busy and only zones 0..2 are taken.
*/
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module ebzat_top (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [ebzat_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ebzat_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ebzat_pkg::DATA_W-1:0] reg_rdata_out,
  // Access request from the on-chip master
  input wire logic access_req_in,
  input wire logic access_wr_in,
  input wire logic [ebzat_pkg::ZONE_W-1:0] access_zone_in,
  output logic access_ready_out,
  output logic access_done_out,
  // External bus pins
  input wire logic ext_ready_input_in,
  output logic ext_bus_clock_out,
  output logic [ebzat_pkg::ZONES-1:0] zone_select_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out
);

  // Per-zone timing storage; settings are never checked
  logic [ebzat_pkg::ZT_W-1:0] zone_timing_reg [ebzat_pkg::ZONES];
  logic [ebzat_pkg::ZT_W-1:0] zone_timing_next [ebzat_pkg::ZONES];
  logic clk_half_reg;  // Bus clock at half timing clock
  logic clk_half_next;
  logic [ebzat_pkg::DATA_W-1:0] rdata_reg; // Read data, one cycle late
  logic [ebzat_pkg::DATA_W-1:0] rdata_next;

  // Sequencer state
  ebzat_pkg::ebzat_state_e state_reg;
  ebzat_pkg::ebzat_state_e state_next;
  logic [ebzat_pkg::LEN_W-1:0] cnt_reg; // Cycles left in phase, minus one
  logic [ebzat_pkg::LEN_W-1:0] cnt_next;
  logic [ebzat_pkg::WS_W-1:0] ws_reg;   // Wait states this access
  logic [ebzat_pkg::WS_W-1:0] ws_next;
  logic [ebzat_pkg::WS_W-1:0] last_ws_reg; // Wait states of last access
  logic [ebzat_pkg::WS_W-1:0] last_ws_next;
  logic [ebzat_pkg::ZT_W-1:0] acc_timing_reg; // Timing latched at request
  logic [ebzat_pkg::ZT_W-1:0] acc_timing_next;
  logic acc_wr_reg;
  logic acc_wr_next;
  logic [ebzat_pkg::ZONE_W-1:0] acc_zone_reg;
  logic [ebzat_pkg::ZONE_W-1:0] acc_zone_next;
  logic done_reg;
  logic done_next;

  // Bus clock phase and pin outputs
  logic ext_clk_reg;
  logic ext_clk_next;
  logic [ebzat_pkg::ZONES-1:0] zsel_n_reg;
  logic [ebzat_pkg::ZONES-1:0] zsel_n_next;
  logic rd_n_reg;
  logic rd_n_next;
  logic wr_n_reg;
  logic wr_n_next;

  // Ready path
  logic ready_sync;      // After two flops
  logic ready_late_reg;  // Extra stage for the asynchronous mode
  logic ready_late_next;
  logic ready_ok;        // Ready as seen by the sequencer

  // Phase lengths of the current access
  logic [ebzat_pkg::LEN_W-1:0] lead_len;
  logic [ebzat_pkg::LEN_W-1:0] active_len;
  logic [ebzat_pkg::LEN_W-1:0] trail_len;
  logic ready_en;
  logic ready_async;
  logic req_ok;          // Request names an existing zone

  ebzat_ready_sync u_ready_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(ext_ready_input_in),
    .sync_out(ready_sync)
  );

  ebzat_phase_len u_phase_len (
    .timing_in(acc_timing_reg),
    .wr_in(acc_wr_reg),
    .lead_len_out(lead_len),
    .active_len_out(active_len),
    .trail_len_out(trail_len),
    .ready_en_out(ready_en),
    .ready_async_out(ready_async)
  );

  // Timing writes during an access reach only the next one (word latched)
  // Register writes and read data
  always_comb begin
    for (int z = 0; z < ebzat_pkg::ZONES; z++) begin
      zone_timing_next[z] = zone_timing_reg[z];
    end
    clk_half_next = clk_half_reg;
    rdata_next = '0; // Unmapped or idle reads give zero
    if (reg_wr_in) begin
      for (int z = 0; z < ebzat_pkg::ZONES; z++) begin
        // One aligned word per zone
        if (reg_addr_in == ebzat_pkg::ADDR_W'(ebzat_pkg::OFS_ZONE0 + 4 * z)) begin
          zone_timing_next[z] = reg_wdata_in[ebzat_pkg::ZT_W-1:0];
        end
      end
      if (reg_addr_in == ebzat_pkg::OFS_CTRL) begin
        clk_half_next = reg_wdata_in[ebzat_pkg::F_CLK_HALF];
      end
    end
    if (reg_rd_in) begin
      for (int z = 0; z < ebzat_pkg::ZONES; z++) begin
        if (reg_addr_in == ebzat_pkg::ADDR_W'(ebzat_pkg::OFS_ZONE0 + 4 * z)) begin
          rdata_next = {{(ebzat_pkg::DATA_W-ebzat_pkg::ZT_W){1'b0}}, zone_timing_reg[z]};
        end
      end
      if (reg_addr_in == ebzat_pkg::OFS_CTRL) begin
        rdata_next[ebzat_pkg::F_CLK_HALF] = clk_half_reg;
        rdata_next[ebzat_pkg::F_BUSY] = (state_reg != ebzat_pkg::ST_IDLE);
        rdata_next[ebzat_pkg::F_LAST_WS +: ebzat_pkg::WS_W] = last_ws_reg;
      end
    end
    if (!rst_n_in) begin
      for (int z = 0; z < ebzat_pkg::ZONES; z++) begin
        zone_timing_next[z] = ebzat_pkg::ZT_RESET;
      end
      clk_half_next = ebzat_pkg::CLK_HALF_RESET;
      rdata_next = '0;
    end
  end

  // Register file flops
  always_ff @(posedge sys_clk_in) begin
    for (int z = 0; z < ebzat_pkg::ZONES; z++) begin
      zone_timing_reg[z] <= zone_timing_next[z];
    end
    clk_half_reg <= clk_half_next;
    rdata_reg <= rdata_next;
  end

  // Ready qualification: async mode trades one cycle for more settling
  // Sync mode reads the synchroniser output directly; its lag sets the minimum active
  always_comb begin
    ready_late_next = rst_n_in ? ready_sync : 1'b1;
    ready_ok = ready_async ? ready_late_reg : ready_sync;
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ws_next = ws_reg;
    last_ws_next = last_ws_reg;
    acc_timing_next = acc_timing_reg;
    acc_wr_next = acc_wr_reg;
    acc_zone_next = acc_zone_reg;
    done_next = 1'b0;
    // Bus clock toggles in half mode, stays high at full rate
    ext_clk_next = clk_half_reg ? ~ext_clk_reg : 1'b1;
    req_ok = access_req_in && (32'(access_zone_in) < ebzat_pkg::ZONES);
    case (state_reg)
      ebzat_pkg::ST_IDLE: begin
        if (req_ok) begin
          // Latch the target zone's own settings
          acc_timing_next = zone_timing_reg[access_zone_in];
          acc_wr_next = access_wr_in;
          acc_zone_next = access_zone_in;
          ws_next = '0;
          // Select rises one edge after the setup cycle; align so that
          // it meets a rising bus clock edge, never a falling one
          if (clk_half_reg && !ext_clk_reg) begin
            state_next = ebzat_pkg::ST_ALIGN;
          end else begin
            state_next = ebzat_pkg::ST_LEAD;
          end
        end
      end
      ebzat_pkg::ST_ALIGN: begin
        state_next = ebzat_pkg::ST_LEAD;
      end
      default: begin
      end
    endcase
    // Entering lead: one setup cycle first, selects still high
    // The phase lengths come from the word latched at the request, so
    // they only settle during this cycle; all ones in the count marks it.
    // A real count never reaches all ones: the longest active is 15.
    if (state_next == ebzat_pkg::ST_LEAD && state_reg != ebzat_pkg::ST_LEAD) begin
      cnt_next = '1;
    end
    case (state_reg)
      ebzat_pkg::ST_LEAD: begin
        if (cnt_reg == '1) begin
          // Setup over: load the lead, or skip an empty one unchecked
          if (lead_len == '0) begin
            state_next = ebzat_pkg::ST_ACTIVE;
            cnt_next = active_len - 5'h01;
          end else begin
            cnt_next = lead_len - 5'h01;
          end
        end else if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 5'h01;
        end else begin
          state_next = ebzat_pkg::ST_ACTIVE;
          cnt_next = active_len - 5'h01;
        end
      end
      ebzat_pkg::ST_ACTIVE: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 5'h01;
        end else if (ready_en && !ready_ok) begin
          // Held off by the device: one more active cycle
          // Saturates, so a stuck ready shows 255 rather than a wrapped count
          if (ws_reg != '1) begin
            ws_next = ws_reg + 8'h01;
          end
        end else if (trail_len != '0) begin
          state_next = ebzat_pkg::ST_TRAIL;
          cnt_next = trail_len - 5'h01;
        end else begin
          state_next = ebzat_pkg::ST_IDLE;
          last_ws_next = ws_reg;
          done_next = 1'b1;
        end
      end
      ebzat_pkg::ST_TRAIL: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 5'h01;
        end else begin
          state_next = ebzat_pkg::ST_IDLE;
          last_ws_next = ws_reg;
          done_next = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // Strobes follow the state after the edge
    zsel_n_next = '1;
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    // Setup cycle leaves the selects high, so the pins never show a
    // lead that the latched timing has not sized yet
    if ((state_next == ebzat_pkg::ST_LEAD && cnt_next != '1) ||
        state_next == ebzat_pkg::ST_ACTIVE || state_next == ebzat_pkg::ST_TRAIL) begin
      zsel_n_next[acc_zone_next] = 1'b0;
    end
    if (state_next == ebzat_pkg::ST_ACTIVE) begin
      rd_n_next = acc_wr_next;
      wr_n_next = ~acc_wr_next;
    end
    if (!rst_n_in) begin
      state_next = ebzat_pkg::ST_IDLE;
      cnt_next = '0;
      ws_next = '0;
      last_ws_next = '0;
      acc_timing_next = ebzat_pkg::ZT_RESET;
      acc_wr_next = 1'b0;
      acc_zone_next = '0;
      done_next = 1'b0;
      ext_clk_next = 1'b1;
      zsel_n_next = '1;
      rd_n_next = 1'b1;
      wr_n_next = 1'b1;
    end
  end

  // Sequencer flops
  always_ff @(posedge sys_clk_in) begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    ws_reg <= ws_next;
    last_ws_reg <= last_ws_next;
    acc_timing_reg <= acc_timing_next;
    acc_wr_reg <= acc_wr_next;
    acc_zone_reg <= acc_zone_next;
    done_reg <= done_next;
    ext_clk_reg <= ext_clk_next;
    zsel_n_reg <= zsel_n_next;
    rd_n_reg <= rd_n_next;
    wr_n_reg <= wr_n_next;
    ready_late_reg <= ready_late_next;
  end

  // Outputs
  assign reg_rdata_out = rdata_reg;
  assign access_ready_out = (state_reg == ebzat_pkg::ST_IDLE);
  assign access_done_out = done_reg;
  assign ext_bus_clock_out = ext_clk_reg;
  assign zone_select_n_out = zsel_n_reg;
  assign read_strobe_n_out = rd_n_reg;
  assign write_strobe_n_out = wr_n_reg;

endmodule : ebzat_top

// ### testbench/ebzat_chk_assertions.sv
/*
  Pin checker for the zone access sequencer.
  Assumes it is bound to ebzat_top and sees one clock.
*/
`timescale 1ns/1ps
module ebzat_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Access handshake
  input wire logic access_ready_out,
  input wire logic access_done_out,
  // External bus pins
  input wire logic ext_bus_clock_out,
  input wire logic [ebzat_pkg::ZONES-1:0] zone_select_n_out,
  input wire logic read_strobe_n_out,
  input wire logic write_strobe_n_out
);
  // One domain, so one default clock and reset
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Some zone selected
  wire logic sel_any = ~&zone_select_n_out;
  // Some strobe low
  wire logic stb_any = ~(read_strobe_n_out & write_strobe_n_out);

  a_strobe_in_sel: assert property (stb_any |-> sel_any) else $error("strobe outside select");
  a_one_strobe: assert property (read_strobe_n_out | write_strobe_n_out) else $error("both strobes low");
  a_one_zone: assert property ($onehot0(~zone_select_n_out)) else $error("two zones selected");
  a_lead_on_rise: assert property ($rose(sel_any) |-> ext_bus_clock_out) else $error("lead off bus clock");
  a_lead_first: assert property ($rose(sel_any) |-> !stb_any) else $error("strobe without lead");
  a_zone_held: assert property (sel_any && $past(sel_any) |-> $stable(zone_select_n_out))
    else $error("zone changed mid access");
  a_done_release: assert property ($fell(sel_any) |-> access_done_out) else $error("done not at release");
  a_done_idle: assert property (access_done_out |-> !sel_any && !stb_any && access_ready_out)
    else $error("done while bus active");
  a_done_pulse: assert property (access_done_out |=> !access_done_out) else $error("done too long");
  a_busy_refuse: assert property (sel_any |-> !access_ready_out) else $error("ready during access");

  // Main scenarios reached
  c_read: cover property ($fell(read_strobe_n_out));
  c_write: cover property ($fell(write_strobe_n_out));
  c_half: cover property ($rose(sel_any) && $rose(ext_bus_clock_out));
endmodule : ebzat_chk

bind ebzat_top ebzat_chk u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .access_ready_out(access_ready_out), .access_done_out(access_done_out),
  .ext_bus_clock_out(ext_bus_clock_out), .zone_select_n_out(zone_select_n_out),
  .read_strobe_n_out(read_strobe_n_out), .write_strobe_n_out(write_strobe_n_out));

// ### testbench/ebzat_mem_model.sv
/*
  Far-side memory model: answers on the ready pin.
  Assumes the bench sets stall_in before each access.
*/
`timescale 1ns/1ps
module ebzat_mem_model (
  // Clock
  input wire logic sys_clk_in,
  // Selects from the sequencer
  input wire logic [2:0] zone_select_n_in,
  // Hold-off length in cycles
  input wire logic [7:0] stall_in,
  // Ready to the sequencer
  output logic ready_out
);
  int cnt = 0; // Cycles since select fell
  // Restart outside an access
  always @(posedge sys_clk_in) begin
    if (&zone_select_n_in) cnt <= 0;
    else cnt <= cnt + 1;
  end
  // Slow device holds ready low early; pull-up when idle
  assign ready_out = (&zone_select_n_in) | (cnt >= stall_in);
endmodule : ebzat_mem_model

// ### testbench/ext_bus_zone_access_timing_bench.sv
/*
  Self-checking bench: register tasks, access runs, phase counting.
  Assumes ebzat_top, the memory model and the bound checker.
*/
`timescale 1ns/1ps
module ext_bus_zone_access_timing_bench;
  logic sys_clk_in, rst_n_in, rwr, rrd, req, wr, ready, clr, ck;
  logic [7:0] addr, stall; // Register address, model hold-off
  logic [31:0] wdata, rdata;
  logic [1:0] zone;
  logic [2:0] sel_n, zs; // Selects, zones seen
  logic rd_n, wr_n, done, rdy, bclk;
  logic [16:0] zt [3]; // Bench copy of zone timing words
  int lead_n, stb_n, oth_n, trl_n, mismatches, cmp_count;

  ebzat_top dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdata),
    .access_req_in(req), .access_wr_in(wr), .access_zone_in(zone), .access_ready_out(rdy),
    .access_done_out(done), .ext_ready_input_in(ready), .ext_bus_clock_out(bclk),
    .zone_select_n_out(sel_n), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n));
  ebzat_mem_model mem (.sys_clk_in(sys_clk_in), .zone_select_n_in(sel_n), .stall_in(stall), .ready_out(ready));

  // Clock, 50 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // Phase counters; lead before strobe, trail after it
  always @(posedge sys_clk_in) begin
    if (clr) begin
      {lead_n, stb_n, oth_n, trl_n, zs} = '0;
    end else if (sel_n !== 3'h7) begin
      zs = zs | ~sel_n;
      if (lead_n + stb_n + trl_n == 0) ck = bclk;
      if (!(wr ? wr_n : rd_n)) stb_n++;
      else if (stb_n == 0) lead_n++;
      else trl_n++;
      if (!(wr ? rd_n : wr_n)) oth_n++;
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    rwr <= 1'b1;
    @(posedge sys_clk_in);
    rwr <= 1'b0;
  endtask : wr_reg
  // Read; data stands only in the next cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    rrd <= 1'b1;
    @(posedge sys_clk_in);
    rrd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Build a timing word: rd lead, active, trail, wr ditto, flags
  function automatic logic [16:0] mk(input logic [2:0] rl, ra, rt, wl, wa, wt, input logic d, e, y);
    mk = {y, e, d, wt[1:0], wa, wl[1:0], rt[1:0], ra, rl[1:0]};
  endfunction : mk
  // Program a zone and read it back
  task automatic setz(input logic [1:0] z, input logic [16:0] t);
    logic [31:0] d;
    zt[z] = t;
    wr_reg(8'h04 * z, {15'h0000, t});
    rd_reg(8'h04 * z, d);
    chk(d, {15'h0000, t});
  endtask : setz
  // One access with expected phase lengths from the zone word
  task automatic run(input logic w, input logic [1:0] z, input logic [7:0] st);
    logic [6:0] s;
    logic [31:0] d;
    int l, a, r, ws, n;
    s = w ? zt[z][13:7] : zt[z][6:0];
    l = s[1:0];
    a = s[4:2];
    r = s[6:5];
    if (zt[z][14]) {l, a, r} = {2 * l, 2 * a, 2 * r};
    @(posedge sys_clk_in);
    stall <= st;
    {clr, req, wr, zone} <= {1'b1, 1'b1, w, z};
    @(posedge sys_clk_in);
    {clr, req} <= 2'h0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge sys_clk_in);
      #1 n++;
    end
    chk(n < 300, 1);
    rd_reg(8'h0c, d);
    ws = d[23:16];
    if (!zt[z][15] || st == 0) chk(ws, 0);
    else chk(ws != 0, 1);
    chk(lead_n, l);
    chk(stb_n, a + ws + 1);
    chk(trl_n, r);
    chk({zs, oth_n != 0}, {3'h1 << z, 1'b0});
    chk(ck, 1);
    $display("access zone %0d write %0d done", z, w);
  endtask : run
  // Verdict, reached once
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  // Test sequence
  initial begin
    logic [31:0] d;
    {rst_n_in, rwr, rrd, req, wr, clr} = '0;
    {addr, wdata, zone, stall} = '0;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'h04 * i, d);
      chk(d, (i < 3) ? {15'h0000, ebzat_pkg::ZT_RESET} : 32'h00000000);
    end
    wr_reg(8'h10, 32'hffffffff);
    rd_reg(8'h10, d);
    chk(d, 32'h00000000);
    $display("reset values done");
    setz(2'h0, mk(1, 0, 0, 1, 0, 0, 0, 0, 0));
    run(1'b0, 2'h0, 8'h00);
    setz(2'h1, mk(3, 7, 3, 2, 3, 1, 0, 0, 0));
    run(1'b1, 2'h1, 8'h00);
    run(1'b0, 2'h1, 8'h00);
    setz(2'h2, mk(1, 2, 2, 3, 1, 3, 1, 0, 0));
    run(1'b0, 2'h2, 8'h00);
    run(1'b1, 2'h2, 8'h00);
    setz(2'h0, mk(1, 1, 1, 1, 1, 1, 0, 0, 0));
    run(1'b0, 2'h0, 8'h06);
    setz(2'h1, mk(1, 2, 1, 1, 2, 1, 0, 1, 0));
    run(1'b0, 2'h1, 8'h08);
    run(1'b1, 2'h1, 8'h00);
    setz(2'h2, mk(2, 1, 0, 2, 1, 0, 1, 1, 1));
    run(1'b1, 2'h2, 8'h08);
    setz(2'h0, mk(1, 0, 0, 1, 0, 0, 0, 1, 0));
    run(1'b0, 2'h0, 8'h00);
    wr_reg(8'h0c, 32'h00000001);
    run(1'b0, 2'h1, 8'h00);
    run(1'b1, 2'h0, 8'h00);
    @(posedge sys_clk_in);
    {clr, req, zone} <= {1'b1, 1'b1, 2'h3};
    @(posedge sys_clk_in);
    clr <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    req <= 1'b0;
    #1 chk({zs, rdy}, 4'h1);
    $display("zone three refused done");
    conclude();
  end
endmodule : ext_bus_zone_access_timing_bench
